// ==== design/ddz_core.sv ====
// Droop, zero-servo position lock and torque-mode control core.
`timescale 1ns/1ps
module ddz_core
  import ddz_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  // Run and inputs from the host
  input  wire logic               run_cmd,
  input  wire logic [N_MFI-1:0]   mfi_pin,
  input  wire logic [N_MFI*8-1:0] multifunction_input_selector,
  input  wire logic [N_MFO*8-1:0] multifunction_output_selector,
  // Encoder phases
  input  wire logic               enc_a,
  input  wire logic               enc_b,
  // Settings
  input  wire logic [9:0]         droop_gain,
  input  wire logic [7:0]         droop_delay,
  input  wire logic [6:0]         lock_gain,
  input  wire logic [13:0]        lock_window_count,
  input  wire logic [15:0]        zero_speed_level,
  input  wire logic               torque_mode_select,
  input  wire logic [7:0]         aux_analog_function,
  input  wire logic [7:0]         current_input_function,
  input  wire logic [1:0]         aux_analog_level,
  input  wire logic [1:0]         current_input_level,
  input  wire logic [1:0]         speed_limit_source,
  input  wire logic signed [15:0] speed_limit_setting,
  // Analog values and feedback
  input  wire logic signed [15:0] speed_ref,
  input  wire logic signed [15:0] motor_speed,
  input  wire logic signed [15:0] motor_torque,
  input  wire logic signed [15:0] aux_analog_in,
  input  wire logic signed [15:0] current_input_in,
  input  wire logic signed [15:0] freq_ref_in,
  // Outputs
  output logic                    output_enable,
  output logic [N_MFO-1:0]        mfo_pin,
  output logic signed [31:0]      position,
  output logic signed [15:0]      speed_cmd,
  output logic signed [15:0]      torque_cmd,
  output logic                    torque_mode,
  output logic                    lock_active
);
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic sel_has(input logic [N_MFI*8-1:0] s, input int n,
                                   input logic [7:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < n; i++)
      if (s[i*8 +: 8] == code)
        r = 1'b1;
    return r;
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sd32767)
      return 16'sh7fff;
    else if (v < -32'sd32768)
      return 16'sh8000;
    else
      return v[15:0];
  endfunction

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  logic [N_MFI+1:0] sync1_r;
  logic [N_MFI+1:0] sync2_r;
  logic [1:0]       ab_prev_r;
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      sync1_r   <= '0;
      sync2_r   <= '0;
      ab_prev_r <= 2'h0;
    end
    else
    begin
      sync1_r   <= {enc_a, enc_b, mfi_pin};
      sync2_r   <= sync1_r;
      ab_prev_r <= sync2_r[N_MFI+1:N_MFI];
    end
  end
  wire logic [1:0] ab_s = sync2_r[N_MFI+1:N_MFI];

  // ---------------------------------------------------------------------------
  // Settings latched only when stopped
  // ---------------------------------------------------------------------------
  logic [6:0]  lock_gain_r;
  logic [13:0] lock_win_r;
  logic        tmode_r;
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      lock_gain_r <= LOCK_GAIN_RST;
      lock_win_r  <= LOCK_WIN_RST;
      tmode_r     <= 1'b0;
    end
    else if (!run_cmd)
    begin
      lock_gain_r <= (lock_gain > LOCK_GAIN_MAX) ? LOCK_GAIN_MAX : lock_gain;
      lock_win_r  <= lock_window_count;
      tmode_r     <= torque_mode_select;
    end
  end

  // ---------------------------------------------------------------------------
  // Quadrature decoder
  // ---------------------------------------------------------------------------
  // Gray order 00,01,11,10 forward; each edge of either phase counts once.
  logic signed [31:0] pos_r;
  wire logic fwd = (ab_prev_r == 2'b00 && ab_s == 2'b01) || (ab_prev_r == 2'b01 && ab_s == 2'b11)
                || (ab_prev_r == 2'b11 && ab_s == 2'b10) || (ab_prev_r == 2'b10 && ab_s == 2'b00);
  wire logic rev = (ab_prev_r == 2'b01 && ab_s == 2'b00) || (ab_prev_r == 2'b11 && ab_s == 2'b01)
                || (ab_prev_r == 2'b10 && ab_s == 2'b11) || (ab_prev_r == 2'b00 && ab_s == 2'b10);
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      pos_r <= '0;
    else if (fwd)
      pos_r <= pos_r + 32'sd1;
    else if (rev)
      pos_r <= pos_r - 32'sd1;
  end

  // ---------------------------------------------------------------------------
  // Zero-servo lock state machine
  // ---------------------------------------------------------------------------
  wire logic lock_en  = sel_has(multifunction_input_selector, N_MFI, FN_LOCK_CMD);
  logic      lock_cmd;
  always_comb
  begin
    lock_cmd = 1'b0;
    for (int i = 0; i < N_MFI; i++)
      if (multifunction_input_selector[i*8 +: 8] == FN_LOCK_CMD && sync2_r[i])
        lock_cmd = 1'b1;
  end
  wire logic signed [15:0] ref_abs = speed_ref[15] ? -speed_ref : speed_ref;
  wire logic below_zs = $unsigned(ref_abs) < zero_speed_level;

  ddz_state_t         st_r;
  logic signed [31:0] start_r;
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      st_r    <= DDZ_IDLE;
      start_r <= '0;
    end
    else
    begin
      case (st_r)
        DDZ_IDLE:
          if (run_cmd && lock_en && lock_cmd)
            st_r <= DDZ_WAIT;
        DDZ_WAIT:
          if (!run_cmd || !lock_cmd)
            st_r <= DDZ_IDLE;
          else if (below_zs)
          begin
            st_r    <= DDZ_LOCK;
            start_r <= pos_r;
          end
        DDZ_LOCK:
          if (!run_cmd || !lock_cmd || !lock_en)
            st_r <= DDZ_IDLE;
        default:
          st_r <= DDZ_IDLE;
      endcase
    end
  end
  wire logic locked = (st_r == DDZ_LOCK) && run_cmd && lock_cmd;

  // Deviation each cycle against the latched start.
  wire logic signed [31:0] dev = pos_r - start_r;
  wire logic signed [31:0] dev_abs = dev[31] ? -dev : dev;
  wire logic in_window = dev_abs <= $signed({18'h0, lock_win_r});
  wire logic done_used = sel_has({{((N_MFI-N_MFO)*8){1'b0}}, multifunction_output_selector},
                                 N_MFO, FN_LOCK_DONE);

  // Position loop: correction opposes deviation, scaled by the frozen gain.
  wire logic signed [31:0] hold_corr = -(dev * $signed({25'h0, lock_gain_r}));

  // ---------------------------------------------------------------------------
  // Droop: low-pass of torque, slip proportional to gain
  // ---------------------------------------------------------------------------
  logic [31:0]        dly_cnt_r;
  logic signed [15:0] droop_r;
  wire logic [9:0]  dg  = (droop_gain > DROOP_GAIN_MAX) ? DROOP_GAIN_MAX : droop_gain;
  wire logic [7:0]  dd  = (droop_delay < DROOP_DELAY_MIN) ? DROOP_DELAY_MIN :
                          (droop_delay > DROOP_DELAY_MAX) ? DROOP_DELAY_MAX : droop_delay;
  // Slip target = torque * gain / 1000 at full scale torque and frequency.
  wire logic signed [31:0] droop_tgt = (motor_torque * $signed({22'h0, dg})) / 32'sd1000;
  wire logic signed [15:0] droop_err = sat16(droop_tgt - 32'(droop_r));
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      dly_cnt_r <= '0;
      droop_r   <= '0;
    end
    else if (dg == DROOP_GAIN_RST)
    begin
      dly_cnt_r <= '0;
      droop_r   <= '0;
    end
    // Step toward target every delay interval; delay counts in sixteenths of the step.
    else if (dly_cnt_r >= 32'(DELAY_STEP_CYC) / 32'd16 * 32'(dd))
    begin
      dly_cnt_r <= '0;
      droop_r   <= droop_r + (droop_err >>> 4);
    end
    else
      dly_cnt_r <= dly_cnt_r + 32'd1;
  end

  // ---------------------------------------------------------------------------
  // Torque reference and speed limit
  // ---------------------------------------------------------------------------
  logic signed [15:0] tref;
  logic [1:0]         tlvl;
  always_comb
  begin
    tref = '0;
    tlvl = LVL_UNI;
    if (aux_analog_function == FN_TORQUE_REF)
    begin
      tref = aux_analog_in;
      tlvl = (aux_analog_level == LVL_CUR) ? LVL_UNI : aux_analog_level;
    end
    else if (current_input_function == FN_TORQUE_REF)
    begin
      tref = current_input_in;
      tlvl = current_input_level;
    end
    if (tlvl != LVL_BI && tref[15])
      tref = '0;
  end

  logic signed [15:0] spd_lim;
  always_comb
  begin
    if (speed_limit_source == LIM_SRC_ANALOG)
      spd_lim = (current_input_function == FN_DEFAULT) ?
                sat16(32'(freq_ref_in) + 32'(current_input_in)) : freq_ref_in;
    else
      spd_lim = speed_limit_setting;
  end
  wire logic signed [15:0] lim_abs = spd_lim[15] ? -spd_lim : spd_lim;
  wire logic signed [15:0] spd_abs = motor_speed[15] ? -motor_speed : motor_speed;
  wire logic signed [31:0] excess = 32'(spd_abs) - 32'(lim_abs);
  wire logic signed [31:0] supp = (excess > 0) ? (motor_speed[15] ? excess : -excess) : '0;

  // ---------------------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      output_enable <= 1'b0;
      mfo_pin       <= '0;
      position      <= '0;
      speed_cmd     <= '0;
      torque_cmd    <= '0;
      torque_mode   <= 1'b0;
      lock_active   <= 1'b0;
    end
    else
    begin
      output_enable <= run_cmd;
      position      <= pos_r;
      torque_mode   <= tmode_r;
      lock_active   <= locked;
      for (int i = 0; i < N_MFO; i++)
        mfo_pin[i] <= (multifunction_output_selector[i*8 +: 8] == FN_LOCK_DONE)
                      && done_used && locked && in_window;
      if (!run_cmd)
        speed_cmd <= '0;
      else if (locked)
        speed_cmd <= sat16(hold_corr);
      else
        speed_cmd <= sat16(32'(speed_ref) - 32'(droop_r));
      if (!run_cmd || !tmode_r)
        torque_cmd <= '0;
      else
        torque_cmd <= sat16(32'(tref) + supp);
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  run_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !run_cmd |=> !output_enable && speed_cmd == 16'sh0) else $error("output not cut");
  done_drop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !lock_cmd |=> mfo_pin == '0) else $error("lock done stayed");
  done_win_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (locked && !in_window) |=> mfo_pin == '0) else $error("done outside window");
  done_code_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !done_used |=> mfo_pin == '0) else $error("done without code");
  lock_code_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !lock_en |-> ##1 st_r != DDZ_LOCK || $past(st_r) == DDZ_LOCK)
    else $error("lock without code");
  start_latch_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r == DDZ_WAIT && $past(st_r) != DDZ_WAIT) ##0 (st_r == DDZ_WAIT) ##1 st_r == DDZ_LOCK
    |-> start_r == $past(pos_r)) else $error("start not latched");
  gain_frozen_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    run_cmd && $past(run_cmd) |-> $stable(lock_gain_r) && $stable(lock_win_r) && $stable(tmode_r))
    else $error("setting changed running");
  quad_fwd_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    fwd |=> pos_r == $past(pos_r) + 32'sd1) else $error("count missed");
  fwd_only_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (run_cmd && tmode_r && tlvl != LVL_BI && supp == 32'sd0) |=> !torque_cmd[15])
    else $error("reverse torque on unipolar");
endmodule

// ==== design/ddz_pkg.sv ====
// Package of constants and types for the droop, zero-servo lock and torque-mode logic.
package ddz_pkg;
  // ---------------------------------------------------------------------------
  // Setting ranges and defaults
  // ---------------------------------------------------------------------------
  localparam logic [9:0]  DROOP_GAIN_MAX   = 10'h3e8;  // 100.0 % in 0.1 % steps
  localparam logic [9:0]  DROOP_GAIN_RST   = 10'h000;
  localparam logic [7:0]  DROOP_DELAY_MIN  = 8'h03;    // 0.03 s in 10 ms steps
  localparam logic [7:0]  DROOP_DELAY_MAX  = 8'hc8;    // 2.00 s
  localparam logic [7:0]  DROOP_DELAY_RST  = 8'h05;    // 0.05 s
  localparam logic [6:0]  LOCK_GAIN_MAX    = 7'h64;    // 100
  localparam logic [6:0]  LOCK_GAIN_RST    = 7'h05;
  localparam logic [13:0] LOCK_WIN_RST     = 14'h000a; // 10 pulses
  localparam logic [7:0]  FN_LOCK_CMD      = 8'h72;    // input code 72
  localparam logic [7:0]  FN_LOCK_DONE     = 8'h33;    // output code 33
  localparam logic [7:0]  FN_TORQUE_REF    = 8'h13;    // analog code 13
  localparam logic [7:0]  FN_DEFAULT       = 8'h1f;
  localparam logic [1:0]  LVL_UNI          = 2'h0;
  localparam logic [1:0]  LVL_BI           = 2'h1;
  localparam logic [1:0]  LVL_CUR          = 2'h2;
  localparam logic [1:0]  LIM_SRC_ANALOG   = 2'h1;
  localparam logic [1:0]  LIM_SRC_SETTING  = 2'h2;
  localparam int          N_MFI            = 6;
  localparam int          N_MFO            = 3;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          CLK_HZ           = 40_000_000;
  localparam int          DELAY_STEP_MS    = 10;
  localparam int          DELAY_STEP_CYC   = CLK_HZ / 1000 * DELAY_STEP_MS;
  typedef enum logic [1:0] {DDZ_IDLE = 2'b00, DDZ_WAIT = 2'b01, DDZ_LOCK = 2'b11} ddz_state_t;
endpackage

// ==== test/ddz_core_tb.sv ====
// Self-checking bench for the droop, zero-servo lock and torque-mode core.
`timescale 1ns/1ps
module ddz_core_tb;
  import ddz_pkg::*;
  logic                    sys_clk = 1'b0;
  logic                    nrst, run_cmd, torque_mode_select, step, dir_rev, enc_a, enc_b;
  logic [N_MFI-1:0]        mfi_pin;
  logic [N_MFI*8-1:0]      multifunction_input_selector;
  logic [N_MFO*8-1:0]      multifunction_output_selector;
  logic [9:0]              droop_gain;
  logic [7:0]              droop_delay, aux_analog_function, current_input_function;
  logic [6:0]              lock_gain;
  logic [13:0]             lock_window_count;
  logic [15:0]             zero_speed_level, rnd;
  logic [1:0]              aux_analog_level, current_input_level, speed_limit_source;
  logic signed [15:0]      speed_limit_setting, speed_ref, motor_speed, motor_torque;
  logic signed [15:0]      aux_analog_in, current_input_in, freq_ref_in, speed_cmd, torque_cmd;
  logic                    output_enable, torque_mode, lock_active;
  logic [N_MFO-1:0]        mfo_pin;
  logic signed [31:0]      position;
  int                      err_count = 0;
  int                      cmp_count = 0;

  always #12.5 sys_clk = ~sys_clk;

  ddz_core u_ddz_core (.sys_clk, .nrst, .run_cmd, .mfi_pin, .multifunction_input_selector,
    .multifunction_output_selector, .enc_a, .enc_b, .droop_gain, .droop_delay, .lock_gain,
    .lock_window_count, .zero_speed_level, .torque_mode_select, .aux_analog_function,
    .current_input_function, .aux_analog_level, .current_input_level, .speed_limit_source,
    .speed_limit_setting, .speed_ref, .motor_speed, .motor_torque, .aux_analog_in,
    .current_input_in, .freq_ref_in, .output_enable, .mfo_pin, .position, .speed_cmd,
    .torque_cmd, .torque_mode, .lock_active);
  ddz_enc_model u_ddz_enc_model (.sys_clk, .step, .dir_rev, .enc_a, .enc_b);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // The suppressing term grows with the excess and always opposes rotation.
  function automatic logic signed [15:0] exp_torque(input logic signed [15:0] r,
    input logic bi, input logic signed [15:0] spd, input logic signed [15:0] lim);
    logic signed [15:0] t, m;
    t = (!bi && r < 0) ? 16'sh0 : r;
    m = (lim < 0) ? -lim : lim;
    if (spd > m)
      t = t - (spd - m);
    else if (spd < -m)
      t = t + (-m - spd);
    return t;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic move(input int n);
    int i;
    for (i = 0; i < ((n < 0) ? -n : n); i++)
    begin
      step    = 1'b1;
      dir_rev = (n < 0);
      cyc(1);
      step    = 1'b0;
      cyc(2);
    end
    cyc(6);
  endtask

  task automatic results;
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    int n, i, j, k, g;
    logic signed [15:0] r, e;
    {nrst, run_cmd, torque_mode_select, step, dir_rev, mfi_pin} = '0;
    multifunction_input_selector  = {N_MFI{FN_DEFAULT}};
    multifunction_output_selector = {N_MFO{FN_DEFAULT}};
    {droop_gain, lock_gain, speed_ref, motor_speed, motor_torque} = '0;
    {aux_analog_in, current_input_in, freq_ref_in, speed_limit_setting} = '0;
    droop_delay = DROOP_DELAY_RST;
    lock_window_count = LOCK_WIN_RST;
    zero_speed_level = 16'h0100;
    {aux_analog_function, current_input_function} = {FN_DEFAULT, FN_DEFAULT};
    {aux_analog_level, current_input_level, speed_limit_source} = {LVL_UNI, LVL_CUR, 2'h2};
    rnd = 16'h0003;
    cyc(10);
    chk(32'(output_enable), 32'h0);
    chk(32'(position), 32'h0);
    nrst = 1'b1;
    n = 1 + int'(rnd[3:0]);
    move(n);
    chk(32'(position), 32'(n));
    move(-n - 2);
    chk(32'(position), 32'hffff_fffe);
    run_cmd = 1'b1;
    rnd = lfsr(rnd);
    speed_ref = 16'(rnd[9:0]);
    motor_torque = 16'sh0200;
    cyc(4);
    chk(32'(output_enable), 32'h1);
    chk(32'(speed_cmd), 32'(speed_ref));
    // Droop moves one filter step only after the delay, so watch both sides of it.
    droop_gain = DROOP_GAIN_MAX;
    droop_delay = DROOP_DELAY_MIN;
    e = 16'(int'(motor_torque) * int'(DROOP_GAIN_MAX) / 1000 / 16);
    cyc(DELAY_STEP_CYC / 16 * int'(DROOP_DELAY_MIN) - 4);
    chk(32'(speed_cmd), 32'(speed_ref));
    cyc(8);
    chk(32'(speed_cmd), 32'(speed_ref - e));
    droop_gain = DROOP_GAIN_RST;
    cyc(4);
    chk(32'(speed_cmd), 32'(speed_ref));
    speed_ref = 16'sh0;
    mfi_pin[0] = 1'b1;
    cyc(8);
    chk(32'(lock_active), 32'h0);
    {mfi_pin, run_cmd} = '0;
    rnd = lfsr(rnd);
    k = int'(rnd[2:0]) % N_MFI;
    j = int'(rnd[5:4]) % N_MFO;
    multifunction_input_selector[k*8 +: 8]  = FN_LOCK_CMD;
    multifunction_output_selector[j*8 +: 8] = FN_LOCK_DONE;
    lock_window_count = 14'h0003;
    g = 1 + int'(rnd[5:0]);
    lock_gain = 7'(g);
    cyc(2);
    run_cmd = 1'b1;
    mfi_pin[k] = 1'b1;
    cyc(8);
    chk(32'(lock_active), 32'h1);
    chk(32'(mfo_pin), 32'(3'h1 << j));
    move(3);
    chk(32'(mfo_pin), 32'(3'h1 << j));
    chk(32'(speed_cmd), 32'(-3 * g));
    move(1);
    chk(32'(mfo_pin), 32'h0);
    lock_window_count = 14'h0064;
    lock_gain = LOCK_GAIN_MAX;
    cyc(4);
    chk(32'(mfo_pin), 32'h0);
    chk(32'(speed_cmd), 32'(-4 * g));
    move(-1);
    chk(32'(mfo_pin), 32'(3'h1 << j));
    mfi_pin = '0;
    cyc(4);
    chk(32'(mfo_pin), 32'h0);
    mfi_pin[k] = 1'b1;
    cyc(8);
    run_cmd = 1'b0;
    cyc(4);
    chk(32'(output_enable), 32'h0);
    chk(32'(lock_active), 32'h0);
    mfi_pin = '0;
    torque_mode_select = 1'b1;
    cyc(3);
    run_cmd = 1'b1;
    torque_mode_select = 1'b0;
    cyc(3);
    chk(32'(torque_mode), 32'h1);
    torque_mode_select = 1'b1;
    // Cases: bipolar reverse, unipolar reverse, current input over limit, analog limit.
    for (i = 0; i < 4; i++)
    begin
      run_cmd = 1'b0;
      rnd = lfsr(rnd);
      r = 16'(rnd[9:0]);
      e = 16'(rnd[15:12]) + 16'sh1;
      speed_limit_setting = 16'sh0200;
      freq_ref_in = 16'sh0100;
      speed_limit_source = (i == 3) ? LIM_SRC_ANALOG : LIM_SRC_SETTING;
      aux_analog_function = (i < 2) ? FN_TORQUE_REF : FN_DEFAULT;
      current_input_function = (i < 2) ? FN_DEFAULT : FN_TORQUE_REF;
      aux_analog_level = (i == 0) ? LVL_BI : (rnd[10] ? LVL_CUR : LVL_UNI);
      aux_analog_in = -r;
      current_input_in = r;
      motor_speed = (i == 2) ? 16'sh0200 + e : (i == 3) ? -(16'sh0100 + e) : 16'sh0010;
      cyc(2);
      run_cmd = 1'b1;
      cyc(6);
      if (i < 2)
        chk(32'(torque_cmd), 32'(exp_torque(-r, i == 0, motor_speed, 16'sh0200)));
      else
        chk(32'(torque_cmd), 32'(exp_torque(r, 1'b0, motor_speed,
          (i == 3) ? freq_ref_in : speed_limit_setting)));
    end
    results();
  end

  initial
  begin
    #2_250_000;
    err_count++;
    results();
  end
endmodule

// ==== test/ddz_enc_model.sv ====
// Incremental encoder model stepped by the bench.
`timescale 1ns/1ps
module ddz_enc_model
(
  // Clock
  input  wire logic sys_clk,
  // Step requests
  input  wire logic step,
  input  wire logic dir_rev,
  // Encoder phases
  output logic      enc_a,
  output logic      enc_b
);
  logic [1:0] phase_r = 2'h0;

  // One phase edge per step, so each step is worth exactly one count.
  always @(posedge sys_clk)
  begin
    if (step)
      phase_r <= dir_rev ? phase_r - 2'h1 : phase_r + 2'h1;
  end
  assign enc_a = phase_r[1];
  assign enc_b = phase_r[1] ^ phase_r[0];
endmodule
